// ==== dv/rasu_core_properties.sv ====
`timescale 1ns/100ps
module rasu_core_properties #(
   parameter int unsigned DEPTH = rasu_pkg::STACK_DEPTH
) (
   input wire logic                 ref_clk_i,
   input wire logic                 reset_n_i,
   input wire logic                 instr_valid_i,
   input wire rasu_pkg::rasu_flow_t flow_op_i,
   input wire logic                 flow_cond_i,
   input wire logic [15:0]          target_addr_i,
   input wire logic                 two_word_i,
   input wire rasu_pkg::rasu_stk_t  stack_op_i,
   input wire logic [15:0]          acc_low_i,
   input wire logic                 rpt_start_i,
   input wire logic                 global_map_wr_i,
   input wire logic [15:0]          global_map_i,
   input wire logic                 exp_shift_exec_i,
   input wire logic [15:0]          pc_o,
   input wire logic [15:0]          stack_top_o,
   input wire logic                 acc_wr_o,
   input wire logic [15:0]          acc_wr_data_o,
   input wire logic                 dmem_wr_o,
   input wire logic [15:0]          dmem_wr_data_o,
   input wire logic                 flush_o,
   input wire logic                 stall_o,
   input wire logic [15:0]          global_map_o,
   input wire logic                 exp_shift_hazard_o
);
   logic go;
   logic uncond;
   logic sop;
   // requests outside the run state are ignored, so only these may carry a cause
   assign go     = instr_valid_i && !stall_o;
   assign uncond = go && flow_op_i != rasu_pkg::RASU_OP_NONE && !flow_cond_i && !rpt_start_i;
   assign sop    = go && flow_op_i == rasu_pkg::RASU_OP_NONE && !rpt_start_i;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!reset_n_i);
   a_call_push_return:
   assert property (uncond && flow_op_i inside {rasu_pkg::RASU_OP_CALL, rasu_pkg::RASU_OP_INTR}
      |=> stack_top_o == 16'($past(pc_o) + 16'($past(two_word_i)) + 16'h0001))
      else $error("call push wrong");
   a_branch_target:
   assert property (uncond && flow_op_i inside {rasu_pkg::RASU_OP_BRANCH, rasu_pkg::RASU_OP_CALL}
      |=> pc_o == $past(target_addr_i)) else $error("branch target not loaded");
   a_return_top_pc:
   assert property (uncond && flow_op_i == rasu_pkg::RASU_OP_RETURN
      |=> pc_o == $past(stack_top_o)) else $error("return did not load top");
   a_flush_two_words:
   assert property (uncond |=> flush_o [*2] ##1 !flush_o) else $error("flush length wrong");
   a_cond_extra_cycle:
   assert property (go && flow_op_i != rasu_pkg::RASU_OP_NONE && flow_cond_i
      |=> stall_o && !flush_o && $stable(pc_o)) else $error("conditional did not wait");
   a_pop_acc_data:
   assert property (sop && stack_op_i == rasu_pkg::RASU_STK_POP_ACC
      |=> acc_wr_o && acc_wr_data_o == $past(stack_top_o)) else $error("pop to acc wrong");
   a_pop_dmem_data:
   assert property (sop && stack_op_i == rasu_pkg::RASU_STK_POP_DMEM
      |=> dmem_wr_o && dmem_wr_data_o == $past(stack_top_o)) else $error("pop to dmem wrong");
   a_push_acc_top:
   assert property (sop && stack_op_i == rasu_pkg::RASU_STK_PUSH_ACC
      |=> stack_top_o == $past(acc_low_i)) else $error("push acc wrong");
   a_shift_hazard_win:
   assert property (go && exp_shift_exec_i |=> exp_shift_hazard_o [*2])
      else $error("shift hazard window wrong");
endmodule

// ==== dv/rasu_core_test.sv ====
`timescale 1ns/100ps
module rasu_core_test;
   logic                 ref_clk_i = 1'b0;
   logic                 reset_n_i = 1'b0;
   logic                 instr_valid_i, flow_cond_i, cond_all_met_i, two_word_i, rpt_start_i;
   logic                 rpt_last_i, global_map_wr_i, exp_shift_exec_i, acc_wr_o, dmem_wr_o;
   logic                 flush_o, stall_o, exp_shift_hazard_o;
   logic [15:0]          target_addr_i, acc_low_i, dmem_rd_i, rpt_operand_i, global_map_i;
   logic [15:0]          pc_o, fetch_addr_o, stack_top_o, acc_wr_data_o, dmem_wr_data_o;
   logic [15:0]          global_map_o, r, stk [8], pc_m;
   logic [3:0]           stage_busy_o;
   rasu_pkg::rasu_flow_t flow_op_i;
   rasu_pkg::rasu_stk_t  stack_op_i;
   logic [31:0]          seed;
   int                   fail_count, checks_done;
   rasu_core dut (.*);
   always #5 ref_clk_i = ~ref_clk_i;
   function automatic logic [15:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[15:0];
   endfunction
   // model keeps the whole stack so later pops expose any lost or smeared level
   function void push(input logic [15:0] v);
      for (int i = 7; i > 0; i--) stk[i] = stk[i-1];
      stk[0] = v;
   endfunction
   function void pop();
      for (int i = 0; i < 7; i++) stk[i] = stk[i+1];
   endfunction
   task chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checks_done++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report();
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task op(input rasu_pkg::rasu_flow_t f, input logic c, m, input rasu_pkg::rasu_stk_t s);
      logic [15:0] d;
      logic        nf, tk;
      int          n;
      d = rnd();
      nf = f == rasu_pkg::RASU_OP_NONE;
      c = c && !nf;
      tk = !nf && (!c || m);
      {instr_valid_i, flow_cond_i, cond_all_met_i} = {1'b1, c, m};
      flow_op_i = f;
      stack_op_i = s;
      two_word_i = d[2];
      {target_addr_i, acc_low_i, dmem_rd_i, global_map_i} = {d, d, ~d, d[7:0], d[15:8]};
      {global_map_wr_i, exp_shift_exec_i} = {2{nf}} & d[1:0];
      @(posedge ref_clk_i);
      #1 {instr_valid_i, global_map_wr_i, exp_shift_exec_i} = 3'h0;
      chk("stage_fetch", 16'h1, {15'h0, stage_busy_o[0]});
      if (c) begin
         chk("pc_wait", pc_m, pc_o);
         chk("stall_wait", 16'h1, {15'h0, stall_o});
         @(posedge ref_clk_i);
         #1;
      end
      chk("acc_wr", {15'h0, nf && s == rasu_pkg::RASU_STK_POP_ACC}, {15'h0, acc_wr_o});
      chk("dmem_wr", {15'h0, nf && s == rasu_pkg::RASU_STK_POP_DMEM}, {15'h0, dmem_wr_o});
      if (acc_wr_o === 1'b1) chk("acc_data", stk[0], acc_wr_data_o);
      if (dmem_wr_o === 1'b1) chk("dmem_data", stk[0], dmem_wr_data_o);
      if (nf && s == rasu_pkg::RASU_STK_PUSH_ACC) push(d);
      if (nf && s == rasu_pkg::RASU_STK_PUSH_DMEM) push(~d);
      if (nf && s inside {rasu_pkg::RASU_STK_POP_ACC, rasu_pkg::RASU_STK_POP_DMEM}) pop();
      if (nf && d[1]) chk("map", {d[7:0], d[15:8]}, global_map_o);
      if (tk && f == rasu_pkg::RASU_OP_RETURN) begin
         pc_m = stk[0];
         pop();
      end else if (tk) begin
         if (f != rasu_pkg::RASU_OP_BRANCH) push(pc_m + {14'h0, d[2], ~d[2]});
         pc_m = d;
      end else pc_m = pc_m + {14'h0, d[2], ~d[2]};
      chk("pc", pc_m, pc_o);
      chk("fetch_addr", pc_m, fetch_addr_o);
      chk("top", stk[0], stack_top_o);
      n = 0;
      for (int i = 0; i < 6 && stall_o !== 1'b0; i++) begin
         n += int'(flush_o === 1'b1);
         @(posedge ref_clk_i);
         #1;
      end
      chk("flush_cycles", tk ? 16'h2 : 16'h0, 16'(n));
      chk("stall_end", 16'h0, {15'h0, stall_o});
      if (stall_o !== 1'b0) final_report();
   endtask
   initial begin
      seed = 32'd78513;
      {instr_valid_i, flow_cond_i, cond_all_met_i, two_word_i, rpt_start_i} = 5'h00;
      {rpt_last_i, global_map_wr_i, exp_shift_exec_i} = 3'h0;
      {target_addr_i, acc_low_i, dmem_rd_i, rpt_operand_i, global_map_i} = 80'h0;
      flow_op_i = rasu_pkg::RASU_OP_NONE;
      stack_op_i = rasu_pkg::RASU_STK_NONE;
      stk = '{default: 16'h0000};
      pc_m = 16'h0000;
      repeat (20) @(posedge ref_clk_i);
      #1 reset_n_i = 1'b1;
      chk("reset_top", 16'h0000, stack_top_o);
      // overfill by two, then drain past the bottom so the copied bottom shows
      for (int i = 0; i < 10; i++)
         op(rasu_pkg::RASU_OP_NONE, 0, 0, rasu_pkg::RASU_STK_PUSH_ACC);
      for (int i = 0; i < 9; i++)
         op(rasu_pkg::RASU_OP_NONE, 0, 0, rasu_pkg::RASU_STK_POP_DMEM);
      for (int k = 1; k < 5; k++)
         for (int j = 0; j < 3; j++)
            op(rasu_pkg::rasu_flow_t'(3'(k)), j > 0, j == 2, rasu_pkg::RASU_STK_POP_ACC);
      flow_op_i = rasu_pkg::RASU_OP_NONE;
      stack_op_i = rasu_pkg::RASU_STK_NONE;
      {instr_valid_i, rpt_start_i, two_word_i} = 3'h6;
      rpt_operand_i = rnd();
      @(posedge ref_clk_i);
      #1 {instr_valid_i, rpt_start_i} = 2'h0;
      for (int i = 0; i < 3; i++) begin
         r = fetch_addr_o;
         @(posedge ref_clk_i);
         #1 chk("operand_step", r + 16'h0001, fetch_addr_o);
      end
      rpt_last_i = 1'b1;
      @(posedge ref_clk_i);
      #1 rpt_last_i = 1'b0;
      pc_m = pc_m + 16'h0001;
      chk("pc_restore", pc_m, pc_o);
      for (int i = 0; i < 400; i++) begin
         r = rnd();
         op(r[2] ? rasu_pkg::RASU_OP_NONE : rasu_pkg::rasu_flow_t'(3'(r[5:3] % 5)), r[9], r[10],
            rasu_pkg::rasu_stk_t'(3'(r[8:6] % 5)));
      end
      final_report();
   end
endmodule
bind rasu_core rasu_core_properties #(.DEPTH(DEPTH)) u_props (.*);

// ==== verilog/rasu_core.sv ====
`timescale 1ns/100ps
// Behaviour
// (R1) eight-entry, 16-bit return stack, only top entry visible
// (R2) call or interrupt pushes return address in the same cycle, no extra cycles
// (R3) return loads top entry into program counter and pops
// (R4) accumulator push puts low 16 accumulator bits on top, entries shift down
// (R5) accumulator pop writes top entry to accumulator low half and pops
// (R6) data-memory push and pop through top entry
// (R7) push shifts all entries down, eighth entry lost, no overflow flag
// (R8) pop shifts entries up, bottom keeps value
// (R9) separate single 16-bit micro return latch
// (R10) repeated two-operand ops save next fetch address, restore on finish
// (R11) during repeat, program counter steps first operand address each iteration
// (R12) micro return latch has no software access path
// (R13) four overlapping pipeline stages: fetch, decode, operand, execute
// (R14) instruction right after global map write still sees old map
// (R15) exponent shift uses execute-stage pointer; next two words change it in decode
// (R16) evaluate combinationally, latch on clock edge; dependent ops take successive cycles
// (R17) branch only redirects; call also pushes following address
// (R18) unconditional always taken; conditional taken only when all conditions hold
// (R19) taken flow change in execute discards two fetched words
// (R20) conditional branch costs one extra cycle over unconditional
// (R21) at most one push or pop per cycle; call push and stack op never coincide
module rasu_core #(
   parameter int unsigned DEPTH = rasu_pkg::STACK_DEPTH
) (
   input  wire logic                           ref_clk_i,
   input  wire logic                           reset_n_i,
   input  wire logic                           instr_valid_i,
   input  wire rasu_pkg::rasu_flow_t           flow_op_i,
   input  wire logic                           flow_cond_i,
   input  wire logic                           cond_all_met_i,
   input  wire logic [rasu_pkg::ADDR_W-1:0]    target_addr_i,
   input  wire logic                           two_word_i,
   input  wire rasu_pkg::rasu_stk_t            stack_op_i,
   input  wire logic [rasu_pkg::ADDR_W-1:0]    acc_low_i,
   input  wire logic [rasu_pkg::ADDR_W-1:0]    dmem_rd_i,
   input  wire logic                           rpt_start_i,
   input  wire logic                           rpt_last_i,
   input  wire logic [rasu_pkg::ADDR_W-1:0]    rpt_operand_i,
   input  wire logic                           global_map_wr_i,
   input  wire logic [rasu_pkg::ADDR_W-1:0]    global_map_i,
   input  wire logic                           exp_shift_exec_i,
   output logic      [rasu_pkg::ADDR_W-1:0]    pc_o,
   output logic      [rasu_pkg::ADDR_W-1:0]    fetch_addr_o,
   output logic      [rasu_pkg::ADDR_W-1:0]    stack_top_o,
   output logic                                acc_wr_o,
   output logic      [rasu_pkg::ADDR_W-1:0]    acc_wr_data_o,
   output logic                                dmem_wr_o,
   output logic      [rasu_pkg::ADDR_W-1:0]    dmem_wr_data_o,
   output logic                                flush_o,
   output logic                                stall_o,
   output logic      [rasu_pkg::ADDR_W-1:0]    global_map_o,
   output logic                                exp_shift_hazard_o,
   output logic      [3:0]                     stage_busy_o
);
   localparam int unsigned AW = rasu_pkg::ADDR_W;

   typedef struct packed {
      logic [DEPTH-1:0][AW-1:0] stk;
      logic [AW-1:0]            micro_return_latch;
      logic                     micro_full;
      logic [AW-1:0]            pc;
      logic [AW-1:0]            operand_ptr;
      rasu_pkg::rasu_state_t    state;
      logic [1:0]               flush_cnt;
      logic [3:0]               stage_busy;
      logic [AW-1:0]            global_map;
      logic [1:0]               exp_win;
      logic                     acc_wr;
      logic [AW-1:0]            acc_wr_data;
      logic                     dmem_wr;
      logic [AW-1:0]            dmem_wr_data;
   } rasu_state_s_t;

   // reset image built from package constants, so a changed reset word lands everywhere
   localparam rasu_state_s_t RESET_STATE = '{
      stk:                {DEPTH{rasu_pkg::RESET_WORD}},
      micro_return_latch: rasu_pkg::RESET_WORD,
      micro_full:         1'b0,
      pc:                 rasu_pkg::RESET_WORD,
      operand_ptr:        rasu_pkg::RESET_WORD,
      state:              rasu_pkg::RASU_PS_RUN,
      flush_cnt:          2'h0,
      stage_busy:         4'h0,
      global_map:         rasu_pkg::RESET_WORD,
      exp_win:            2'h0,
      acc_wr:             1'b0,
      acc_wr_data:        rasu_pkg::RESET_WORD,
      dmem_wr:            1'b0,
      dmem_wr_data:       rasu_pkg::RESET_WORD
   };

   rasu_state_s_t cur;
   rasu_state_s_t next_cur;

   function automatic logic taken(input rasu_pkg::rasu_flow_t op, input logic cnd,
                                  input logic met);
      taken = (op != rasu_pkg::RASU_OP_NONE) && (!cnd || met); // (R18)
   endfunction

   function automatic logic [AW-1:0] seq_step(input logic [AW-1:0] pc, input logic two);
      seq_step = two ? AW'(pc + AW'(2)) : AW'(pc + AW'(1));
   endfunction

   logic do_push;
   logic do_pop;
   logic [AW-1:0] push_val;
   logic take;
   logic [DEPTH-1:1][AW-1:0] shifted_down;
   logic [DEPTH-2:0][AW-1:0] shifted_up;

   // both shift networks are always built; one choice below picks at most one of them
   generate
      for (genvar g = 1; g < DEPTH; g++) begin : gen_shift
         assign shifted_down[g] = cur.stk[g-1]; // (R7)
         assign shifted_up[g-1] = cur.stk[g];   // (R8)
      end
   endgenerate

   always_comb begin
      next_cur = cur;
      next_cur.acc_wr = 1'b0;
      next_cur.dmem_wr = 1'b0;
      do_push = 1'b0;
      do_pop = 1'b0;
      push_val = '0;
      take = 1'b0;
      // every stage advances each cycle; the shift register tracks occupancy
      next_cur.stage_busy = {cur.stage_busy[2:0],
                             instr_valid_i && cur.state == rasu_pkg::RASU_PS_RUN}; // (R13) (R16)
      // decode-stage pointer changes land before the shift executes
      next_cur.exp_win = exp_shift_exec_i ? 2'(rasu_pkg::EXPONENT_SHIFT_INSTRUCTION_WIN) :
                         (cur.exp_win != 2'h0 ? 2'(cur.exp_win - 2'h1) : 2'h0); // (R15)
      // new map is registered, so the very next instruction still sees the old one
      if (global_map_wr_i) begin
         next_cur.global_map = global_map_i; // (R14)
      end
      case (cur.state)
         rasu_pkg::RASU_PS_RUN: begin
            if (instr_valid_i) begin
               take = taken(flow_op_i, flow_cond_i, cond_all_met_i);
               if (flow_op_i != rasu_pkg::RASU_OP_NONE && flow_cond_i) begin
                  // conditions settle one cycle after the previous instruction
                  next_cur.state = rasu_pkg::RASU_PS_COND_WAIT; // (R20)
               end else if (rpt_start_i) begin
                  next_cur.micro_return_latch = seq_step(cur.pc, two_word_i); // (R10)
                  next_cur.micro_full = 1'b1;
                  next_cur.operand_ptr = rpt_operand_i;
                  next_cur.state = rasu_pkg::RASU_PS_REPEAT;
               end else if (take) begin
                  case (flow_op_i)
                     rasu_pkg::RASU_OP_CALL, rasu_pkg::RASU_OP_INTR: begin
                        do_push = 1'b1; // (R2) (R17)
                        push_val = seq_step(cur.pc, two_word_i);
                        next_cur.pc = target_addr_i;
                     end
                     rasu_pkg::RASU_OP_RETURN: begin
                        do_pop = 1'b1;
                        next_cur.pc = cur.stk[0]; // (R3)
                     end
                     default: next_cur.pc = target_addr_i; // (R17)
                  endcase
                  next_cur.state = rasu_pkg::RASU_PS_FLUSH; // (R19)
                  next_cur.flush_cnt = 2'(rasu_pkg::FLUSH_WORDS);
               end else begin
                  // explicit stack ops only without flow change (R21)
                  case (stack_op_i)
                     rasu_pkg::RASU_STK_PUSH_ACC: begin
                        do_push = 1'b1;
                        push_val = acc_low_i; // (R4)
                     end
                     rasu_pkg::RASU_STK_PUSH_DMEM: begin
                        do_push = 1'b1;
                        push_val = dmem_rd_i; // (R6)
                     end
                     rasu_pkg::RASU_STK_POP_ACC: begin
                        do_pop = 1'b1;
                        next_cur.acc_wr = 1'b1;
                        next_cur.acc_wr_data = cur.stk[0]; // (R5)
                     end
                     rasu_pkg::RASU_STK_POP_DMEM: begin
                        do_pop = 1'b1;
                        next_cur.dmem_wr = 1'b1;
                        next_cur.dmem_wr_data = cur.stk[0]; // (R6)
                     end
                     default: ;
                  endcase
                  next_cur.pc = seq_step(cur.pc, two_word_i);
               end
            end
         end
         rasu_pkg::RASU_PS_COND_WAIT: begin
            take = taken(flow_op_i, flow_cond_i, cond_all_met_i); // (R18)
            if (take) begin
               case (flow_op_i)
                  rasu_pkg::RASU_OP_CALL, rasu_pkg::RASU_OP_INTR: begin
                     do_push = 1'b1; // (R17)
                     push_val = seq_step(cur.pc, two_word_i);
                     next_cur.pc = target_addr_i;
                  end
                  rasu_pkg::RASU_OP_RETURN: begin
                     do_pop = 1'b1;
                     next_cur.pc = cur.stk[0]; // (R3)
                  end
                  default: next_cur.pc = target_addr_i;
               endcase
               next_cur.state = rasu_pkg::RASU_PS_FLUSH; // (R19)
               next_cur.flush_cnt = 2'(rasu_pkg::FLUSH_WORDS);
            end else begin
               // not taken: the two fetched words execute normally
               next_cur.pc = seq_step(cur.pc, two_word_i);
               next_cur.state = rasu_pkg::RASU_PS_RUN;
            end
         end
         rasu_pkg::RASU_PS_FLUSH: begin
            next_cur.flush_cnt = 2'(cur.flush_cnt - 2'h1);
            if (cur.flush_cnt == 2'h1) begin
               next_cur.state = rasu_pkg::RASU_PS_RUN;
            end
         end
         rasu_pkg::RASU_PS_REPEAT: begin
            next_cur.operand_ptr = AW'(cur.operand_ptr + AW'(1)); // (R11)
            if (rpt_last_i) begin
               next_cur.pc = cur.micro_return_latch; // (R10)
               next_cur.micro_full = 1'b0;
               next_cur.state = rasu_pkg::RASU_PS_RUN;
            end
         end
         default: next_cur.state = rasu_pkg::RASU_PS_RUN;
      endcase
      // one if/else below picks push over pop, so push and pop are exclusive (R21)
      if (do_push) begin
         next_cur.stk[DEPTH-1:1] = shifted_down; // (R7)
         next_cur.stk[0]         = push_val;
      end else if (do_pop) begin
         // bottom entry is left as it was, so repeated pops copy it upward
         next_cur.stk[DEPTH-2:0] = shifted_up; // (R8)
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cur <= RESET_STATE;
      end else begin
         cur <= next_cur; // (R1) (R9) (R16)
      end
   end

   // the micro latch has no read port toward software (R12)
   assign pc_o               = cur.pc;
   assign fetch_addr_o       = (cur.state == rasu_pkg::RASU_PS_REPEAT) ? cur.operand_ptr : cur.pc;
   assign stack_top_o        = cur.stk[0]; // (R1)
   assign acc_wr_o           = cur.acc_wr;
   assign acc_wr_data_o      = cur.acc_wr_data;
   assign dmem_wr_o          = cur.dmem_wr;
   assign dmem_wr_data_o     = cur.dmem_wr_data;
   assign flush_o            = (cur.state == rasu_pkg::RASU_PS_FLUSH); // (R19)
   assign stall_o            = (cur.state != rasu_pkg::RASU_PS_RUN);
   assign global_map_o       = cur.global_map;
   assign exp_shift_hazard_o = (cur.exp_win != 2'h0);
   assign stage_busy_o       = cur.stage_busy;
endmodule

// ==== verilog/rasu_pkg.sv ====
package rasu_pkg;
   localparam int unsigned ADDR_W      = 16;
   localparam int unsigned STACK_DEPTH = 8;
   localparam int unsigned FLUSH_WORDS = 2;
   localparam int unsigned COND_EXTRA  = 1;
   localparam int unsigned EXPONENT_SHIFT_INSTRUCTION_WIN    = 2;
   localparam logic [15:0] RESET_WORD  = 16'h0000;

   typedef enum logic [2:0] {
      RASU_OP_NONE,
      RASU_OP_BRANCH,
      RASU_OP_CALL,
      RASU_OP_RETURN,
      RASU_OP_INTR
   } rasu_flow_t;

   typedef enum logic [2:0] {
      RASU_STK_NONE,
      RASU_STK_PUSH_ACC,
      RASU_STK_POP_ACC,
      RASU_STK_PUSH_DMEM,
      RASU_STK_POP_DMEM
   } rasu_stk_t;

   typedef enum logic [1:0] {
      RASU_PS_RUN,
      RASU_PS_COND_WAIT,
      RASU_PS_FLUSH,
      RASU_PS_REPEAT
   } rasu_state_t;
endpackage
